// *** sim/analog_model.sv ***
`timescale 1ns/10ps
module analog_model #(
   parameter int SETTLE      = 6,
   parameter int VREG_SETTLE = 12
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_osc_on,
   input  wire logic i_target,
   output logic      o_osc_stable,
   output logic      o_vreg_stable
);
   logic [3:0] osc_cnt_q;
   logic [3:0] vreg_cnt_q;
   logic       last_tgt_q;

   // A new target drops both stables one clock later, so a stale stable still shows for one cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_cnt_q  <= 4'h0;
         vreg_cnt_q <= 4'h0;
         last_tgt_q <= 1'h0;
      end else begin
         last_tgt_q <= i_target;
         if (i_target !== last_tgt_q) begin
            osc_cnt_q  <= 4'h0;
            vreg_cnt_q <= 4'h0;
         end else begin
            if (!i_osc_on) osc_cnt_q <= 4'h0;
            else if (osc_cnt_q < 4'(SETTLE)) osc_cnt_q <= osc_cnt_q + 4'h1;
            // Regulator settles well after the oscillator, so an exit that skips it shows
            if (vreg_cnt_q < 4'(VREG_SETTLE)) vreg_cnt_q <= vreg_cnt_q + 4'h1;
         end
      end
   end

   assign o_osc_stable  = (osc_cnt_q == 4'(SETTLE));
   assign o_vreg_stable = (vreg_cnt_q == 4'(VREG_SETTLE));
endmodule

// *** sim/core_power_state_controller_bench.sv ***
`timescale 1ns/10ps
module core_power_state_controller_bench;
   typedef struct packed {
      logic [1:0] kind;
      logic       busy;
      logic [2:0] st;
      logic [3:0] fl;
      logic       tmr;
   } row_t;

   logic       i_clk, i_rst_n, i_supply_good, i_sys_osc_stable, i_vreg_stable;
   logic       i_other_reset, i_sleep_req, i_level_req, i_level_target, i_irq_valid;
   logic       i_dma_req, i_chip_active, i_core_active, i_timer_fw_en, osc_on;
   logic [1:0] i_sleep_kind;
   logic [2:0] o_state;
   logic       o_module_reset, o_cpu_halt, o_sys_osc_en, o_sys_clk_en;
   logic       o_timer_osc_en, o_run_level, o_level_target;
   int         error_cnt, checks, cycles;
   row_t       rows [5];

   core_power_state_controller core_power_state_controller_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_good(i_supply_good),
      .i_sys_osc_stable(i_sys_osc_stable), .i_vreg_stable(i_vreg_stable),
      .i_other_reset(i_other_reset), .i_sleep_req(i_sleep_req),
      .i_sleep_kind(i_sleep_kind), .i_level_req(i_level_req),
      .i_level_target(i_level_target), .i_irq_valid(i_irq_valid), .i_dma_req(i_dma_req),
      .i_chip_active(i_chip_active), .i_core_active(i_core_active),
      .i_timer_fw_en(i_timer_fw_en), .o_state(o_state), .o_module_reset(o_module_reset),
      .o_cpu_halt(o_cpu_halt), .o_sys_osc_en(o_sys_osc_en), .o_sys_clk_en(o_sys_clk_en),
      .o_timer_osc_en(o_timer_osc_en), .o_run_level(o_run_level),
      .o_level_target(o_level_target));

   // The oscillator starts by itself during power-up
   assign osc_on = o_sys_osc_en | (o_state == core_pwr_pkg::power_up_state);

   analog_model analog_model_i (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_osc_on(osc_on), .i_target(o_level_target),
      .o_osc_stable(i_sys_osc_stable), .o_vreg_stable(i_vreg_stable));

   always #12.5 i_clk = ~i_clk;

   task automatic close_out;
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         $display("MISMATCH at %0t: run timed out", $time);
         close_out;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic expect_st(input logic [2:0] st, input logic [3:0] fl);
      chk({1'h0, o_state, o_module_reset, o_cpu_halt, o_sys_osc_en, o_sys_clk_en},
          {1'h0, st, fl}, "state and flags");
   endtask

   task automatic wait_st(input logic [2:0] st);
      int n;
      n = 0;
      while (o_state !== st && n < 64) begin
         @(negedge i_clk);
         n++;
      end
      chk({5'h0, o_state}, {5'h0, st}, "state reached");
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic pulse_sleep(input logic [1:0] kind);
      i_sleep_req  = 1'h1;
      i_sleep_kind = kind;
      tick(1);
      i_sleep_req  = 1'h0;
   endtask

   task automatic pulse_level(input logic tgt);
      i_level_req    = 1'h1;
      i_level_target = tgt;
      tick(1);
      i_level_req    = 1'h0;
   endtask

   initial begin
      {i_clk, i_rst_n, i_supply_good, i_other_reset, i_sleep_req, i_level_req} = 6'h0;
      {i_level_target, i_irq_valid, i_dma_req, i_chip_active, i_core_active} = 5'h0;
      i_timer_fw_en = 1'h0;
      i_sleep_kind  = 2'h0;
      rows[0] = '{core_pwr_pkg::SLEEP_LIGHT, 1'h0, core_pwr_pkg::light_sleep_state, 4'h7, 1'h1};
      rows[1] = '{core_pwr_pkg::SLEEP_REGULAR, 1'h0, core_pwr_pkg::regular_sleep_state, 4'h4, 1'h1};
      rows[2] = '{core_pwr_pkg::SLEEP_DEEP, 1'h0, core_pwr_pkg::deep_sleep_state, 4'h4, 1'h0};
      rows[3] = '{core_pwr_pkg::SLEEP_REGULAR, 1'h1, core_pwr_pkg::light_sleep_state, 4'h7, 1'h1};
      rows[4] = '{2'h3, 1'h0, core_pwr_pkg::regular_sleep_state, 4'h4, 1'h1};
      tick(2);
      expect_st(core_pwr_pkg::power_up_state, 4'hC);
      chk({7'h0, o_timer_osc_en}, 8'h00, "timer in power-up");
      i_rst_n = 1'h1;
      pulse_level(1'h1);
      tick(8);
      expect_st(core_pwr_pkg::power_up_state, 4'hC);
      i_supply_good = 1'h1;
      i_other_reset = 1'h1;
      tick(8);
      expect_st(core_pwr_pkg::power_up_state, 4'hC);
      i_other_reset = 1'h0;
      wait_st(core_pwr_pkg::level_change_state);
      expect_st(core_pwr_pkg::level_change_state, 4'h6);
      chk({6'h0, o_level_target, o_run_level}, 8'h02, "ramp levels");
      chk({7'h0, o_timer_osc_en}, 8'h00, "timer after power-up");
      wait_st(core_pwr_pkg::active_state);
      chk({7'h0, o_run_level}, 8'h01, "fast level");
      chk({7'h0, i_vreg_stable}, 8'h01, "vreg at ramp exit");
      i_timer_fw_en = 1'h1;
      tick(3);
      chk({7'h0, o_timer_osc_en}, 8'h01, "timer by firmware");
      pulse_level(1'h0);
      tick(2);
      expect_st(core_pwr_pkg::level_change_state, 4'h6);
      chk({7'h0, o_timer_osc_en}, 8'h01, "timer in ramp");
      wait_st(core_pwr_pkg::active_state);
      chk({7'h0, o_run_level}, 8'h00, "slow level");
      chk({7'h0, i_vreg_stable}, 8'h01, "vreg at ramp exit");
      for (int r = 0; r < 5; r++) begin
         i_chip_active = rows[r].busy;
         i_core_active = rows[r].busy;
         pulse_sleep(rows[r].kind);
         tick(2);
         expect_st(rows[r].st, rows[r].fl);
         chk({7'h0, o_timer_osc_en}, {7'h0, rows[r].tmr}, "timer in sleep");
         i_irq_valid = 1'h1;
         wait_st(core_pwr_pkg::active_state);
         chk({7'h0, o_timer_osc_en}, {7'h0, rows[r].tmr}, "timer on wake");
         i_irq_valid   = 1'h0;
         i_chip_active = 1'h0;
         i_core_active = 1'h0;
         tick(3);
      end
      i_chip_active = 1'h1;
      i_core_active = 1'h1;
      pulse_sleep(core_pwr_pkg::SLEEP_REGULAR);
      tick(6);
      expect_st(core_pwr_pkg::light_sleep_state, 4'h7);
      i_chip_active = 1'h0;
      i_core_active = 1'h0;
      wait_st(core_pwr_pkg::regular_sleep_state);
      i_dma_req = 1'h1;
      tick(1);
      i_dma_req = 1'h0;
      tick(2);
      chk({7'h0, o_sys_osc_en}, 8'h01, "osc on after dma");
      wait_st(core_pwr_pkg::light_sleep_state);
      pulse_level(1'h1);
      tick(4);
      expect_st(core_pwr_pkg::light_sleep_state, 4'h7);
      i_irq_valid = 1'h1;
      wait_st(core_pwr_pkg::level_change_state);
      i_irq_valid = 1'h0;
      wait_st(core_pwr_pkg::active_state);
      chk({7'h0, o_run_level}, 8'h01, "level after sleep");
      chk({7'h0, i_vreg_stable}, 8'h01, "vreg at ramp exit");
      // A request for the level already running is dropped
      pulse_level(1'h1);
      tick(3);
      expect_st(core_pwr_pkg::active_state, 4'h3);
      chk({7'h0, o_run_level}, 8'h01, "same level kept");
      // Reset in mid-run returns to power-up and clears the level
      i_rst_n = 1'h0;
      tick(2);
      expect_st(core_pwr_pkg::power_up_state, 4'hC);
      chk({5'h0, o_timer_osc_en, o_level_target, o_run_level}, 8'h00, "in reset");
      i_rst_n = 1'h1;
      wait_st(core_pwr_pkg::active_state);
      chk({7'h0, o_timer_osc_en}, 8'h00, "timer after reset");
      close_out;
   end
endmodule

// *** verilog/core_power_state_controller.sv ***
`timescale 1ns/10ps
// Operation
// - In power-up both oscillators stay off and all digital modules are held in reset.
// - Power-up moves to active only with good supply, stable oscillator and no other reset.
// - Entering active from power-up or deep sleep leaves the timer oscillator off until firmware enables it.
// - A non-light sleep request in active goes straight to regular or deep sleep when the chip is idle, else to light sleep.
// - Light sleep halts the CPU with the system oscillator on, and a valid interrupt returns to active.
// - Light sleep persists for a light request and waits for core idle before regular or deep sleep.
// - Regular sleep turns the system oscillator off, and an interrupt or DMA request turns it back on.
// - After a sleep wake with a stable oscillator, go to active on an interrupt, else to light sleep.
// - Deep sleep acts as regular sleep but also turns the timer oscillator off.
// - The core runs at a 20 MHz or 50 MHz level, available only in active and light sleep.
// - Level switches pass the level-change state, which retargets analog and gates the system clock.
// - The level-change state returns to active only when regulator and oscillator are stable.
module core_power_state_controller (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_supply_good,
   input  wire logic       i_sys_osc_stable,
   input  wire logic       i_vreg_stable,
   input  wire logic       i_other_reset,
   input  wire logic       i_sleep_req,
   input  wire logic [1:0] i_sleep_kind,
   input  wire logic       i_level_req,
   input  wire logic       i_level_target,
   input  wire logic       i_irq_valid,
   input  wire logic       i_dma_req,
   input  wire logic       i_chip_active,
   input  wire logic       i_core_active,
   input  wire logic       i_timer_fw_en,
   output logic      [2:0] o_state,
   output logic            o_module_reset,
   output logic            o_cpu_halt,
   output logic            o_sys_osc_en,
   output logic            o_sys_clk_en,
   output logic            o_timer_osc_en,
   output logic            o_run_level,
   output logic            o_level_target
);

   typedef struct packed {
      core_pwr_pkg::pwr_state_t state;
      logic [1:0]               kind;
      logic                     wake;
      logic                     unstable_seen;
      logic                     timer_on;
      logic                     level;
      logic                     target;
   } ctrl_t;

   ctrl_t q;
   ctrl_t d;

   logic [core_pwr_pkg::ANALOG_WIDTH-1:0] ain_raw;
   logic [core_pwr_pkg::ANALOG_WIDTH-1:0] ain;
   logic       supply_ok;
   logic       osc_ok;
   logic       vreg_ok;
   logic       ext_reset;
   logic       sleep_pend;
   logic [1:0] pend_kind;
   logic       level_pend;
   logic       pend_target;
   logic       take_sleep;
   logic       take_level;

   function automatic logic in_sleep(input core_pwr_pkg::pwr_state_t s);
      in_sleep = (s == core_pwr_pkg::regular_sleep_state) ||
                 (s == core_pwr_pkg::deep_sleep_state);
   endfunction

   function automatic core_pwr_pkg::pwr_state_t sleep_of(input logic [1:0] k);
      sleep_of = (k == core_pwr_pkg::SLEEP_DEEP) ? core_pwr_pkg::deep_sleep_state
                                                 : core_pwr_pkg::regular_sleep_state;
   endfunction

   assign ain_raw[core_pwr_pkg::AIN_SUPPLY] = i_supply_good;
   assign ain_raw[core_pwr_pkg::AIN_OSC]    = i_sys_osc_stable;
   assign ain_raw[core_pwr_pkg::AIN_VREG]   = i_vreg_stable;
   assign ain_raw[core_pwr_pkg::AIN_RESET]  = i_other_reset;

   status_sync status_sync_i (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (ain_raw),
      .o_sync  (ain)
   );

   assign supply_ok = ain[core_pwr_pkg::AIN_SUPPLY];
   assign osc_ok    = ain[core_pwr_pkg::AIN_OSC];
   assign vreg_ok   = ain[core_pwr_pkg::AIN_VREG];
   assign ext_reset = ain[core_pwr_pkg::AIN_RESET];

   request_hold request_hold_i (
      .i_clk          (i_clk),
      .i_rst_n        (i_rst_n),
      .i_sleep_req    (i_sleep_req),
      .i_sleep_kind   (i_sleep_kind),
      .i_level_req    (i_level_req),
      .i_level_target (i_level_target),
      .i_take_sleep   (take_sleep),
      .i_take_level   (take_level),
      .o_sleep_pend   (sleep_pend),
      .o_sleep_kind   (pend_kind),
      .o_level_pend   (level_pend),
      .o_level_target (pend_target)
   );

   // Stable flags are trusted only after a drop was seen, since the analog
   // side may still report the old level for a while after a retarget.
   always_comb begin
      d          = q;
      take_sleep = 1'b0;
      take_level = 1'b0;
      case (q.state)
         core_pwr_pkg::power_up_state: begin
            d.timer_on = 1'b0;
            if (supply_ok && osc_ok && !ext_reset) begin
               d.state = core_pwr_pkg::active_state;
            end
         end
         core_pwr_pkg::active_state: begin
            d.timer_on = i_timer_fw_en;
            if (level_pend) begin
               take_level = 1'b1;
               if (pend_target != q.level) begin
                  d.state         = core_pwr_pkg::level_change_state;
                  d.target        = pend_target;
                  d.unstable_seen = 1'b0;
               end
            end else if (sleep_pend) begin
               take_sleep      = 1'b1;
               d.kind          = pend_kind;
               d.wake          = 1'b0;
               d.unstable_seen = 1'b0;
               if (pend_kind == core_pwr_pkg::SLEEP_LIGHT || i_chip_active) begin
                  d.state = core_pwr_pkg::light_sleep_state;
               end else begin
                  d.state = sleep_of(pend_kind);
               end
            end
         end
         core_pwr_pkg::light_sleep_state: begin
            if (i_irq_valid) begin
               d.state = core_pwr_pkg::active_state;
            end else if (q.kind != core_pwr_pkg::SLEEP_LIGHT && !i_core_active) begin
               d.state         = sleep_of(q.kind);
               d.wake          = 1'b0;
               d.unstable_seen = 1'b0;
            end
         end
         core_pwr_pkg::regular_sleep_state,
         core_pwr_pkg::deep_sleep_state: begin
            if (q.state == core_pwr_pkg::deep_sleep_state) begin
               d.timer_on = 1'b0;
            end
            if (!osc_ok) begin
               d.unstable_seen = 1'b1;
            end
            if (i_irq_valid || i_dma_req) begin
               d.wake = 1'b1;
            end
            if (q.wake && q.unstable_seen && osc_ok) begin
               d.wake = 1'b0;
               if (i_irq_valid) begin
                  d.state = core_pwr_pkg::active_state;
               end else begin
                  d.state = core_pwr_pkg::light_sleep_state;
                  d.kind  = core_pwr_pkg::SLEEP_LIGHT;
               end
            end
         end
         core_pwr_pkg::level_change_state: begin
            if (!(vreg_ok && osc_ok)) begin
               d.unstable_seen = 1'b1;
            end
            // both stable at the new target
            if (q.unstable_seen && vreg_ok && osc_ok) begin
               d.state = core_pwr_pkg::active_state;
               d.level = q.target;
            end
         end
         default: begin
            d.state = core_pwr_pkg::power_up_state;
         end
      endcase
      if (d.state == core_pwr_pkg::deep_sleep_state) begin
         d.timer_on = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= {core_pwr_pkg::power_up_state, core_pwr_pkg::SLEEP_LIGHT, 1'b0, 1'b0, 1'b0,
               core_pwr_pkg::RESET_LEVEL, core_pwr_pkg::RESET_LEVEL};
      end else begin
         q <= d;
      end
   end

   assign o_state        = q.state;
   assign o_module_reset = (q.state == core_pwr_pkg::power_up_state);
   assign o_cpu_halt     = (q.state != core_pwr_pkg::active_state);
   // oscillator off in sleep until wake
   assign o_sys_osc_en   = (q.state == core_pwr_pkg::active_state) ||
                           (q.state == core_pwr_pkg::light_sleep_state) ||
                           (q.state == core_pwr_pkg::level_change_state) ||
                           (in_sleep(q.state) && q.wake);
   // clock only in active and light sleep
   assign o_sys_clk_en   = (q.state == core_pwr_pkg::active_state) ||
                           (q.state == core_pwr_pkg::light_sleep_state);
   assign o_timer_osc_en = q.timer_on;
   assign o_run_level    = q.level;
   assign o_level_target = q.target;

   power_up_state_outputs_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::power_up_state) |->
         (o_module_reset && !o_timer_osc_en && !o_sys_osc_en && !o_sys_clk_en))
      else $error("power-up outputs wrong");

   power_up_state_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ($past(q.state) == core_pwr_pkg::power_up_state &&
       q.state == core_pwr_pkg::active_state) |->
         $past(supply_ok && osc_ok && !ext_reset))
      else $error("power-up left without good status");

   timer_entry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::active_state &&
       ($past(q.state) == core_pwr_pkg::power_up_state ||
        $past(q.state) == core_pwr_pkg::deep_sleep_state)) |-> !o_timer_osc_en)
      else $error("timer on at active entry");

   sleep_direct_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (take_sleep && pend_kind != core_pwr_pkg::SLEEP_LIGHT && !i_chip_active) |=>
         in_sleep(q.state))
      else $error("idle sleep request not direct");

   light_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::light_sleep_state && i_irq_valid) |=>
         (q.state == core_pwr_pkg::active_state) && !o_cpu_halt)
      else $error("light sleep missed interrupt");

   light_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::light_sleep_state && !i_irq_valid &&
       (q.kind == core_pwr_pkg::SLEEP_LIGHT || i_core_active)) |=>
         (q.state == core_pwr_pkg::light_sleep_state) && o_sys_osc_en && o_cpu_halt)
      else $error("light sleep left early");

   sleep_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (in_sleep(q.state) && !q.wake && (i_irq_valid || i_dma_req)) |=>
         (o_sys_osc_en || q.state == core_pwr_pkg::active_state))
      else $error("wake did not enable oscillator");

   sleep_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (in_sleep($past(q.state)) && !in_sleep(q.state)) |->
         ($past(osc_ok) && (q.state == core_pwr_pkg::active_state) == $past(i_irq_valid)))
      else $error("sleep exit wrong");

   deep_timer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::deep_sleep_state) |-> !o_timer_osc_en)
      else $error("timer on in deep sleep");

   level_change_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_run_level != $past(o_run_level)) |->
         ($past(q.state) == core_pwr_pkg::level_change_state &&
          q.state == core_pwr_pkg::active_state))
      else $error("run level changed outside level change");

   ramp_clock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::level_change_state) |->
         (!o_sys_clk_en && o_level_target != o_run_level))
      else $error("clock not gated in level change");

   ramp_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ($past(q.state) == core_pwr_pkg::level_change_state &&
       q.state != core_pwr_pkg::level_change_state) |-> $past(vreg_ok && osc_ok))
      else $error("level change left while unstable");

   hold_req_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state != core_pwr_pkg::active_state) |-> (!take_sleep && !take_level))
      else $error("request taken outside active");

   light_leave_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (q.state == core_pwr_pkg::light_sleep_state && !i_irq_valid &&
       q.kind != core_pwr_pkg::SLEEP_LIGHT && !i_core_active) |=>
         (q.state == sleep_of($past(q.kind))))
      else $error("light sleep missed core idle");

   req_latch_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_sleep_req || i_level_req) |=>
         ((sleep_pend || !$past(i_sleep_req)) && (level_pend || !$past(i_level_req))))
      else $error("request not held");

endmodule

// *** verilog/core_pwr_pkg.sv ***
package core_pwr_pkg;

   typedef enum logic [2:0] {
      power_up_state,
      active_state,
      light_sleep_state,
      regular_sleep_state,
      deep_sleep_state,
      level_change_state
   } pwr_state_t;

   // Sleep kind carried with a sleep request
   localparam logic [1:0] SLEEP_LIGHT   = 2'h0;
   localparam logic [1:0] SLEEP_REGULAR = 2'h1;
   localparam logic [1:0] SLEEP_DEEP    = 2'h2;

   // Run levels: low-speed and high-speed core clock
   localparam logic LEVEL_LOW      = 1'h0;
   localparam logic LEVEL_HIGH     = 1'h1;
   localparam int   LOW_LEVEL_MHZ  = 20;
   localparam int   HIGH_LEVEL_MHZ = 50;
   localparam logic RESET_LEVEL    = LEVEL_LOW;

   // Analog status inputs, synchronised as one vector
   localparam int ANALOG_WIDTH = 4;
   localparam int AIN_SUPPLY   = 0;
   localparam int AIN_OSC      = 1;
   localparam int AIN_VREG     = 2;
   localparam int AIN_RESET    = 3;
   localparam logic [3:0] ANALOG_RESET_VALUE = 4'h0;

endpackage

// *** verilog/request_hold.sv ***
`timescale 1ns/10ps
module request_hold (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_sleep_req,
   input  wire logic [1:0] i_sleep_kind,
   input  wire logic       i_level_req,
   input  wire logic       i_level_target,
   input  wire logic       i_take_sleep,
   input  wire logic       i_take_level,
   output logic            o_sleep_pend,
   output logic      [1:0] o_sleep_kind,
   output logic            o_level_pend,
   output logic            o_level_target
);

   typedef struct packed {
      logic       sleep_pend;
      logic [1:0] sleep_kind;
      logic       level_pend;
      logic       level_target;
   } hold_t;

   hold_t q;
   hold_t d;

   // A new request in the cycle it is taken wins over the take
   always_comb begin
      d = q;
      if (i_take_sleep) begin
         d.sleep_pend = 1'b0;
      end
      if (i_sleep_req) begin
         d.sleep_pend = 1'b1;
         d.sleep_kind = i_sleep_kind;
      end
      if (i_take_level) begin
         d.level_pend = 1'b0;
      end
      if (i_level_req) begin
         d.level_pend   = 1'b1;
         d.level_target = i_level_target;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= {1'b0, core_pwr_pkg::SLEEP_LIGHT, 1'b0, core_pwr_pkg::RESET_LEVEL};
      end else begin
         q <= d;
      end
   end

   assign o_sleep_pend   = q.sleep_pend;
   assign o_sleep_kind   = q.sleep_kind;
   assign o_level_pend   = q.level_pend;
   assign o_level_target = q.level_target;

endmodule

// *** verilog/status_sync.sv ***
`timescale 1ns/10ps
module status_sync (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_rst_n,
   input  wire logic [core_pwr_pkg::ANALOG_WIDTH-1:0] i_async,
   output logic      [core_pwr_pkg::ANALOG_WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [core_pwr_pkg::ANALOG_WIDTH-1:0] meta;
      logic [core_pwr_pkg::ANALOG_WIDTH-1:0] sync;
   } sync_t;

   sync_t q;
   sync_t d;

   // First stage feeds only the second stage
   always_comb begin
      d      = q;
      d.meta = i_async;
      d.sync = q.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= {core_pwr_pkg::ANALOG_RESET_VALUE, core_pwr_pkg::ANALOG_RESET_VALUE};
      end else begin
         q <= d;
      end
   end

   assign o_sync = q.sync;

endmodule
